// ===== design/readout_pkg.sv
// What this block does
// - Each pace channel sets its detected flag at bit 23, 15 or 7 on the pulse's trailing edge.
// - Pace width code is log2(width) minus one, a 3-bit field per channel.
// - Pace height code is log2(height), a 4-bit field per channel.
// - In streamed frames pace and magnitude words go out as two 16-bit halves.
// - Respiration magnitude is an unsigned 24-bit value at its own address.
// - Respiration phase is a 24-bit fraction of a full turn.
// - Respiration phase never appears in frames; only an explicit read returns it.
// - Electrode status bits 23..20 and 13 read one when the electrode is off.
// - With both lead-off methods enabled, status bits 23..20 follow the ac result only.
// - Common electrode status comes from dc detection only.
// - Lead-off and out-of-range flags stick over the frame, clear on buffer transfer.
// - Limb channel out-of-range flags sit at bits 12, 11 and 10.
package readout_pkg;

  // Addresses and the frame-stream command
  localparam logic [7:0] PACE_ADDR       = 8'h1a;
  localparam logic [7:0] RESP_MAG_ADDR   = 8'h1b;
  localparam logic [7:0] RESP_PHASE_ADDR = 8'h1c;
  localparam logic [7:0] STATUS_ADDR     = 8'h1d;
  localparam logic [7:0] FRAME_CMD       = 8'h40;
  localparam int         CMD_WRITE_BIT   = 7;

  // Word widths
  localparam int WORD_W  = 24;
  localparam int ADDR_W  = 8;
  localparam int TX_W    = 32;
  localparam int HALF_W  = 16;
  localparam int FRAME_WORDS = 3;
  localparam int SREG_W  = TX_W * FRAME_WORDS;
  localparam int CNT_W   = 4;

  // Pace word layout, one byte per channel
  localparam int PACE_CH       = 3;
  localparam int PACE_STRIDE   = 8;
  localparam int PACE_DET_POS  = 7;
  localparam int PACE_WID_POS  = 4;
  localparam int PACE_WID_W    = 3;
  localparam int PACE_HGT_POS  = 0;
  localparam int PACE_HGT_W    = 4;

  // Status word layout; index 0 RA, 1 LL, 2 LA, 3 RLD
  localparam int LOFF_POS  = 20;
  localparam int LOFF_W    = 4;
  localparam int CE_POS    = 13;
  localparam int ADCOR_POS = 10;
  localparam int ADCOR_W   = 3;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h00_0000;

  typedef struct packed {
    logic [WORD_W-1:0] pace;
    logic [WORD_W-1:0] mag;
    logic [WORD_W-1:0] phase;
    logic [WORD_W-1:0] status;
  } frame_s;

endpackage

// ===== design/pace_resp_leadoff_readout.sv
`timescale 1ns/100ps
`default_nettype none

module pace_resp_leadoff_readout #(
  parameter int MEAS_W = 16
) (
  input  wire logic                   core_clk,        // Core clock, 200 MHz
  input  wire logic                   srst,            // Reset, active high; synchronous to core_clk, asynchronous in the link domain
  input  wire logic [2:0]             pace_end,        // Pace trailing-edge strobes
  input  wire logic [2:0][MEAS_W-1:0] pace_width,      // Width in 128 kHz periods
  input  wire logic [2:0][MEAS_W-1:0] pace_height,     // Height in reference steps
  input  wire logic                   resp_valid,      // New respiration result
  input  wire logic [23:0]            resp_mag_in,     // Respiration magnitude
  input  wire logic [23:0]            resp_phase_in,   // Respiration phase
  input  wire logic                   ac_loff_en,      // Ac lead-off enabled
  input  wire logic                   dc_loff_en,      // Dc lead-off enabled
  input  wire logic [3:0]             ac_loff,         // Ac result: RLD, LA, LL, RA
  input  wire logic [3:0]             dc_loff,         // Dc result: RLD, LA, LL, RA
  input  wire logic                   dc_ce_off,       // Dc result, common electrode
  input  wire logic                   conv_valid,      // Limb conversions valid
  input  wire logic [2:0][23:0]       conv_code,       // Codes: LA, LL, RA at 2..0
  input  wire logic [23:0]            conv_min,        // Lowest valid code
  input  wire logic [23:0]            conv_max,        // Highest valid code
  input  wire logic                   frame_load,      // Frame buffer to output buffer
  output logic                        buf_busy,        // Output buffer crossing
  output logic                        frame_taken,     // Transfer accepted pulse
  input  wire logic                   link_clk,        // Serial port clock
  input  wire logic                   cs_n,            // Serial select, active low
  input  wire logic                   sdi,             // Serial data in
  output logic                        sdo,             // Serial data out
  output logic                        sdo_oe           // Drive enable for sdo
);

  // Field layout is fixed by the word format
  initial begin
    if (MEAS_W < 2 || MEAS_W > 16) begin
      $error("MEAS_W must lie in 2..16");
    end
  end

  localparam int W = readout_pkg::WORD_W;

  // Index of highest set bit, zero for a zero input
  function automatic logic [4:0] msb_idx(input logic [MEAS_W-1:0] v);
    logic [4:0] r;
    r = 5'h0;
    for (int i = 0; i < MEAS_W; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // ---------------- Core domain ----------------

  logic [2:0]                       det_reg;
  logic [2:0]                       det_next;
  logic [2:0][2:0]                  wid_reg;
  logic [2:0][2:0]                  wid_next;
  logic [2:0][3:0]                  hgt_reg;
  logic [2:0][3:0]                  hgt_next;
  logic [W-1:0]                     mag_reg;
  logic [W-1:0]                     phase_reg;
  logic [3:0]                       loff_now;
  logic                             ce_now;
  logic [2:0]                       adcor_now;
  logic [3:0]                       loff_reg;
  logic                             ce_reg;
  logic [2:0]                       adcor_reg;
  logic [W-1:0]                     pace_word;
  logic [W-1:0]                     status_word;
  logic                             take;
  readout_pkg::frame_s              hold_reg;
  logic                             req_reg;
  logic                             ack_meta;
  logic                             ack_sync;
  logic                             ack_lnk;

  // A new transfer is refused until the previous one has crossed
  assign buf_busy = (req_reg != ack_sync);
  assign take     = frame_load & ~buf_busy;

  // Width and height codes; a fresh strobe replaces the held codes
  always_comb begin
    logic [4:0] wm;
    logic [4:0] hm;
    wm       = 5'h0;
    hm       = 5'h0;
    wid_next = wid_reg;
    hgt_next = hgt_reg;
    for (int c = 0; c < readout_pkg::PACE_CH; c++) begin
      if (pace_end[c]) begin
        wm = msb_idx(pace_width[c]);
        hm = msb_idx(pace_height[c]);
        // Saturate at the field's top and floor at zero
        if (wm == 5'h0) begin
          wid_next[c] = 3'h0;
        end else if (wm > 5'h8) begin
          wid_next[c] = 3'h7;
        end else begin
          wid_next[c] = 3'(wm - 5'h1);
        end
        hgt_next[c] = (hm > 5'hf) ? 4'hf : 4'(hm);
      end
    end
  end

  // Detected flags: a strobe in the clearing cycle survives
  assign det_next = pace_end | (det_reg & ~{3{take}});

  always_ff @(posedge core_clk) begin
    if (srst) begin
      det_reg <= 3'h0;
      wid_reg <= '0;
      hgt_reg <= '0;
    end else begin
      det_reg <= det_next;
      wid_reg <= wid_next;
      hgt_reg <= hgt_next;
    end
  end

  // Pace summary word, reserved bits none, all fields packed per byte
  always_comb begin
    pace_word = readout_pkg::WORD_RESET;
    for (int c = 0; c < readout_pkg::PACE_CH; c++) begin
      pace_word[c*readout_pkg::PACE_STRIDE + readout_pkg::PACE_DET_POS] = det_reg[c] | pace_end[c];
      pace_word[c*readout_pkg::PACE_STRIDE + readout_pkg::PACE_WID_POS +: readout_pkg::PACE_WID_W] =
        wid_next[c];
      pace_word[c*readout_pkg::PACE_STRIDE + readout_pkg::PACE_HGT_POS +: readout_pkg::PACE_HGT_W] =
        hgt_next[c];
    end
  end

  // Respiration results, latest value kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mag_reg   <= readout_pkg::WORD_RESET;
      phase_reg <= readout_pkg::WORD_RESET;
    end else if (resp_valid) begin
      mag_reg   <= resp_mag_in;
      phase_reg <= resp_phase_in;
    end
  end

  // Lead-off source: ac wins when both methods run
  assign loff_now = ac_loff_en ? ac_loff : (dc_loff_en ? dc_loff : 4'h0);
  // Common electrode has no ac measurement
  assign ce_now   = dc_loff_en & dc_ce_off;

  // Out-of-range compare per limb channel
  for (genvar g = 0; g < readout_pkg::ADCOR_W; g++) begin : g_range
    assign adcor_now[g] = conv_valid & ((conv_code[g] < conv_min) | (conv_code[g] > conv_max));
  end

  // Sticky status, set wins over the transfer clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      loff_reg  <= 4'h0;
      ce_reg    <= 1'b0;
      adcor_reg <= 3'h0;
    end else begin
      loff_reg  <= loff_now | (loff_reg & ~{4{take}});
      ce_reg    <= ce_now | (ce_reg & ~take);
      adcor_reg <= adcor_now | (adcor_reg & ~{3{take}});
    end
  end

  // Status word; reserved bits stay zero
  always_comb begin
    status_word = readout_pkg::WORD_RESET;
    status_word[readout_pkg::LOFF_POS +: readout_pkg::LOFF_W]   = loff_reg | loff_now;
    status_word[readout_pkg::CE_POS]                            = ce_reg | ce_now;
    status_word[readout_pkg::ADCOR_POS +: readout_pkg::ADCOR_W] = adcor_reg | adcor_now;
  end

  // Output buffer snapshot, stable while the link copies it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_reg    <= '0;
      req_reg     <= 1'b0;
      frame_taken <= 1'b0;
    end else begin
      frame_taken <= take;
      if (take) begin
        hold_reg.pace   <= pace_word;
        hold_reg.mag    <= resp_valid ? resp_mag_in : mag_reg;
        hold_reg.phase  <= resp_valid ? resp_phase_in : phase_reg;
        hold_reg.status <= status_word;
        req_reg         <= ~req_reg;
      end
    end
  end

  // Acknowledge toggle back from the link side
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_lnk;
      ack_sync <= ack_meta;
    end
  end

  // ---------------- Link domain ----------------

  logic                             req_meta;
  logic                             req_sync;
  readout_pkg::frame_s              copy_reg;
  logic [readout_pkg::CNT_W-1:0]    cnt_reg;
  logic [readout_pkg::ADDR_W-1:0]   cmd_reg;
  logic [readout_pkg::ADDR_W-1:0]   cmd_full;
  logic [readout_pkg::SREG_W-1:0]   sreg;
  logic [readout_pkg::SREG_W-1:0]   load_val;

  // Reset acts without the link clock, which may stand still;
  // release is not aligned to it, a one-edge slip is harmless here
  always_ff @(posedge link_clk or posedge srst) begin
    if (srst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      ack_lnk  <= 1'b0;
      copy_reg <= '0;
    end else begin
      req_meta <= req_reg;
      req_sync <= req_meta;
      if (req_sync != ack_lnk) begin
        copy_reg <= hold_reg;
        ack_lnk  <= req_sync;
      end
    end
  end

  assign cmd_full = {cmd_reg[readout_pkg::ADDR_W-2:0], sdi};

  // Reply chosen once the command byte is complete
  always_comb begin
    load_val = '0;
    if (!cmd_full[readout_pkg::CMD_WRITE_BIT]) begin
      unique case (cmd_full)
        readout_pkg::FRAME_CMD: begin
          // High half of each word leaves first, so a 16-bit framer sees two halves
          load_val = {readout_pkg::PACE_ADDR, copy_reg.pace,
                      readout_pkg::RESP_MAG_ADDR, copy_reg.mag,
                      readout_pkg::STATUS_ADDR, copy_reg.status};
        end
        readout_pkg::PACE_ADDR: begin
          load_val[readout_pkg::SREG_W-1 -: readout_pkg::TX_W] = {cmd_full, copy_reg.pace};
        end
        readout_pkg::RESP_MAG_ADDR: begin
          load_val[readout_pkg::SREG_W-1 -: readout_pkg::TX_W] = {cmd_full, copy_reg.mag};
        end
        readout_pkg::RESP_PHASE_ADDR: begin
          load_val[readout_pkg::SREG_W-1 -: readout_pkg::TX_W] = {cmd_full, copy_reg.phase};
        end
        readout_pkg::STATUS_ADDR: begin
          load_val[readout_pkg::SREG_W-1 -: readout_pkg::TX_W] = {cmd_full, copy_reg.status};
        end
        default: begin
          load_val = '0;
        end
      endcase
    end
  end

  // Command shift-in then reply shift-out; deselect clears it all
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= '0;
      cmd_reg <= '0;
      sreg    <= '0;
    end else if (cnt_reg < readout_pkg::CNT_W'(readout_pkg::ADDR_W)) begin
      cnt_reg <= cnt_reg + 1'b1;
      cmd_reg <= cmd_full;
      if (cnt_reg == readout_pkg::CNT_W'(readout_pkg::ADDR_W - 1)) begin
        sreg <= load_val;
      end
    end else begin
      sreg <= {sreg[readout_pkg::SREG_W-2:0], 1'b0};
    end
  end

  // Pin driven only while selected
  assign sdo    = sreg[readout_pkg::SREG_W-1];
  assign sdo_oe = ~cs_n;

endmodule

`default_nettype wire

// ===== design/HANDOVER_END.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== bench/readout_checker.sv
`timescale 1ns/100ps
`default_nettype none

module readout_checker (
  input wire logic core_clk,    // Core clock
  input wire logic srst,        // Sync reset
  input wire logic frame_load,  // Take request
  input wire logic buf_busy,    // Crossing busy
  input wire logic frame_taken, // Take pulse
  input wire logic cs_n,        // Serial select
  input wire logic sdo,         // Serial out
  input wire logic sdo_oe       // Serial drive enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Take handshake, refusal while the snapshot is still crossing
  a_take_ack: assert property (frame_load && !buf_busy |=> frame_taken && buf_busy)
    else $error("accepted take not acknowledged");
  a_load_refused: assert property (frame_load && buf_busy |=> !frame_taken)
    else $error("take accepted while busy");
  a_taken_cause: assert property (frame_taken |-> $past(frame_load) && !$past(buf_busy))
    else $error("take pulse without request");
  a_taken_single: assert property (frame_taken |=> !frame_taken)
    else $error("take pulse longer than one cycle");
  // Busy spans at least a few cycles and ends once the link has clocked the copy
  a_busy_held: assert property ($rose(buf_busy) |-> buf_busy [*4])
    else $error("busy dropped too early");
  a_busy_bounded: assert property ($rose(buf_busy) |-> ##[1:600] !buf_busy)
    else $error("busy never ended");
  // Serial output only driven inside a select, and quiet outside it
  a_oe_follows: assert property (sdo_oe == !cs_n)
    else $error("drive enable not following select");
  a_sdo_quiet: assert property (cs_n |-> !sdo)
    else $error("serial out active while deselected");
endmodule

bind pace_resp_leadoff_readout readout_checker readout_checker_inst (.core_clk(core_clk), .srst(srst),
  .frame_load(frame_load), .buf_busy(buf_busy), .frame_taken(frame_taken), .cs_n(cs_n), .sdo(sdo),
  .sdo_oe(sdo_oe));

`default_nettype wire

// ===== bench/serial_host.sv
`timescale 1ns/100ps
`default_nettype none

// Host end of the serial port; its clock stands still between selects
module serial_host (
  output logic      link_clk, // Serial clock
  output logic      cs_n,     // Select, active low
  output logic      sdi,      // Command bits
  input  wire logic sdo       // Reply bits
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b0;
    sdi = 1'b0;
    // A clean rising select edge clears the shifter before first use
    #1 cs_n = 1'b1;
  end


  // One select: 8 command bits, n reply bits taken before each falling edge
  // Phase is fetched only by its own read, never from a frame
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [95:0] rx);
    rx = '0;
    #37 cs_n = 1'b0;
    for (int k = 0; k < n + 7; k++) begin
      sdi = (k < 8) ? cmd[7 - k] : ~sdi; // Released line toggles, not holding old data
      #80 link_clk = 1'b1;
      #80 if (k >= 7) rx = {rx[94:0], sdo};
      link_clk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

`default_nettype wire

// ===== bench/pace_resp_leadoff_readout_test.sv
`timescale 1ns/100ps
`default_nettype none

module pace_resp_leadoff_readout_test;
  logic             core_clk = 1'b0;
  logic             srst = 1'b0;
  logic             resp_valid = 1'b0, conv_valid = 1'b0, frame_load = 1'b0;
  logic             ac_loff_en = 1'b0, dc_loff_en = 1'b0, dc_ce_off = 1'b0;
  logic [2:0]       pace_end = '0;
  logic [2:0][15:0] pace_width = '0, pace_height = '0;
  logic [23:0]      resp_mag_in = '0, resp_phase_in = '0;
  logic [3:0]       ac_loff = '0, dc_loff = '0;
  logic [2:0][23:0] conv_code = '0;
  logic [23:0]      conv_min = 24'h00_0100, conv_max = 24'hff_0000;
  logic             buf_busy, frame_taken, link_clk, cs_n, sdi, sdo, sdo_oe;
  logic [95:0]      rx;
  int               fails = 0;
  int               comparisons = 0;

  pace_resp_leadoff_readout pace_resp_leadoff_readout_inst (.core_clk, .srst, .pace_end, .pace_width,
    .pace_height, .resp_valid, .resp_mag_in, .resp_phase_in, .ac_loff_en, .dc_loff_en, .ac_loff, .dc_loff,
    .dc_ce_off, .conv_valid, .conv_code, .conv_min, .conv_max, .frame_load, .buf_busy, .frame_taken,
    .link_clk, .cs_n, .sdi, .sdo, .sdo_oe);
  serial_host serial_host_inst (.link_clk, .cs_n, .sdi, .sdo);

  always #2.5 core_clk = ~core_clk;

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] cmd, input int n, input logic [95:0] exp, input string what);
    serial_host_inst.xfer(cmd, n, rx);
    check(what, rx, exp);
  endtask

  // Move the frame across; a second request while busy must be refused
  task automatic take(input logic twice);
    int k;
    @(posedge core_clk) frame_load <= 1'b1;
    @(posedge core_clk) frame_load <= twice;
    #1 check("taken", frame_taken, 1'b1);
    @(posedge core_clk) frame_load <= 1'b0;
    #1 check("taken once", frame_taken, 1'b0);
    // Write command only keeps the link clock running for the copy
    rd(8'h80, 8, '0, "write reply");
    for (k = 0; k < 400 && buf_busy !== 1'b0; k++) @(posedge core_clk);
    check("busy", buf_busy, 1'b0);
  endtask

  task automatic sc_reset;
    rd(8'h1b, 32, {64'h0, 8'h1b, 24'h00_0000}, "mag reset");
    rd(8'h1c, 32, {64'h0, 8'h1c, 24'h00_0000}, "phase reset");
  endtask

  // Events on all channels, both lead-off methods on, two limb codes out of range
  task automatic sc_frame;
    @(posedge core_clk) begin
      pace_end <= 3'h7;
      pace_width <= {16'h0002, 16'h0100, 16'h0004};
      pace_height <= {16'h8000, 16'h0001, 16'h0008};
      resp_valid <= 1'b1;
      resp_mag_in <= 24'h12_3456;
      resp_phase_in <= 24'hc0_0000;
      {ac_loff_en, dc_loff_en, dc_ce_off} <= 3'h7;
      ac_loff <= 4'h5;
      dc_loff <= 4'ha;
      conv_valid <= 1'b1;
      conv_code <= {24'h00_0010, 24'h80_0000, 24'hff_ffff};
    end
    @(posedge core_clk) begin
      pace_end <= 3'h0;
      resp_valid <= 1'b0;
      conv_valid <= 1'b0;
    end
    take(1'b1);
    rd(8'h40, 96, {8'h1a, 24'h8f_f093, 8'h1b, 24'h12_3456, 8'h1d, 24'h50_3400}, "frame 1");
    rd(8'h1c, 32, {64'h0, 8'h1c, 24'hc0_0000}, "phase");
  endtask

  // Flags clear at the take; only levels still present set them again
  task automatic sc_clear;
    @(posedge core_clk) ac_loff_en <= 1'b0;
    take(1'b0);
    rd(8'h40, 96, {8'h1a, 24'h0f_7013, 8'h1b, 24'h12_3456, 8'h1d, 24'hf0_2000}, "frame 2");
    rd(8'h9b, 32, '0, "write mag");
    rd(8'h1b, 32, {64'h0, 8'h1b, 24'h12_3456}, "mag kept");
    rd(8'h33, 32, '0, "unmapped");
    @(posedge core_clk) dc_loff_en <= 1'b0;
    take(1'b0);
    rd(8'h1d, 32, {64'h0, 8'h1d, 24'ha0_2000}, "status stuck");
    take(1'b0);
    rd(8'h1d, 32, {64'h0, 8'h1d, 24'h00_0000}, "status off");
  endtask

  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    // Rising reset edge so the link-side flops clear too
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    sc_reset;
    sc_frame;
    sc_clear;
    test_done;
  end

  // Run needs about 100 us; cut a hang well past that
  initial begin
    #300_000;
    fails++;
    test_done;
  end
endmodule

`default_nettype wire
